//--- design/cpu_interrupt_flag_control.sv
// Interrupt gate, stack choice and priority level flags of a small CPU core.
// Functional notes
// - Maskable interrupts blocked while gate flag is 0, allowed while it is 1.
// - Acknowledging any interrupt clears the gate flag to 0.
// - Stack choice 0 selects kernel stack pointer, 1 selects user stack pointer.
// - Hardware interrupt acknowledge or trap numbers 0 to 31 clear stack choice.
// - Priority level field is 3 bits, levels 0 to 7.
// - A request is enabled only if its priority exceeds the current level.
// - Reserved flag bit should be written 0; its read value is undefined.
// - Low level on the reset input puts the block in reset.
// - Wake pin ends power-off mode; tie it low when unused.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module cpu_interrupt_flag_control (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [intflag_pkg::ADDR_W-1:0] addr_i,
  input wire logic [intflag_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [intflag_pkg::DATA_W-1:0] rdata_o,
  input wire intflag_pkg::irq_req_t irq_i,
  input wire logic irq_ack_i,
  input wire logic irq_ack_hw_i,
  input wire intflag_pkg::trap_req_t trap_i,
  input wire logic power_off_req_i,
  input wire logic power_off_wake_pin_i,
  output logic irq_take_o,
  output logic user_stack_sel_o,
  output logic [intflag_pkg::PRIO_W-1:0] processor_priority_level_o,
  output logic power_off_o
);
  import intflag_pkg::*;

  logic gate;
  logic next_gate;
  logic stack_sel;
  logic next_stack_sel;
  logic [PRIO_W-1:0] prio_lvl;
  logic [PRIO_W-1:0] next_prio_lvl;
  logic rsvd;
  logic next_rsvd;
  logic irq_take;
  logic next_irq_take;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  power_state_t pstate;
  power_state_t next_pstate;
  // Registered copy of the power-off state so that the output comes from a flip-flop.
  logic power_off;
  logic next_power_off;
  logic flag_wr;
  logic kernel_trap;

  function automatic logic accept(input logic g, input logic [PRIO_W-1:0] lvl,
                                  input irq_req_t r);
    accept = r.valid && g && (r.prio > lvl);
  endfunction : accept

  function automatic logic [DATA_W-1:0] flag_word(input logic g, input logic s,
                                                  input logic [PRIO_W-1:0] lvl,
                                                  input logic r);
    logic [DATA_W-1:0] w;
    w = '0;
    w[GATE_BIT] = g;
    w[STACK_BIT] = s;
    w[PRIO_LSB +: PRIO_W] = lvl;
    w[RSVD_BIT] = r;
    flag_word = w;
  endfunction : flag_word

  assign flag_wr = wr_i && (addr_i == FLAG_OFFSET);
  assign kernel_trap = trap_i.valid && (trap_i.number <= TRAP_KERNEL_MAX);

  // Acknowledge wins over a software write in the same cycle, so the
  // hardware entry into a handler always lands with interrupts closed.
  always_comb begin
    next_gate = gate;
    next_stack_sel = stack_sel;
    next_prio_lvl = prio_lvl;
    next_rsvd = rsvd;
    if (flag_wr) begin
      next_gate = wdata_i[GATE_BIT];
      next_stack_sel = wdata_i[STACK_BIT];
      next_prio_lvl = wdata_i[PRIO_LSB +: PRIO_W];
      next_rsvd = wdata_i[RSVD_BIT];
    end
    if (irq_ack_i) begin
      next_gate = 1'h0;
    end
    if ((irq_ack_i && irq_ack_hw_i) || kernel_trap) begin
      next_stack_sel = 1'h0;
    end
  end

  always_comb begin
    next_irq_take = accept(gate, prio_lvl, irq_i) && !irq_ack_i && (pstate == ST_ON);
    next_rdata = '0;
    if (rd_i && addr_i == FLAG_OFFSET) begin
      next_rdata = flag_word(gate, stack_sel, prio_lvl, rsvd);
    end else if (rd_i && addr_i == STATUS_OFFSET) begin
      next_rdata = {{(DATA_W-2){1'b0}}, pstate};
    end
  end

  // The wake pin is sampled as a plain level; a pin tied low never wakes.
  always_comb begin
    next_pstate = pstate;
    unique case (pstate)
      ST_ON: if (power_off_req_i) next_pstate = ST_OFF;
      ST_OFF: if (power_off_wake_pin_i) next_pstate = ST_WAKE;
      ST_WAKE: next_pstate = ST_ON;
      default: next_pstate = ST_ON;
    endcase
    next_power_off = (next_pstate != ST_ON);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate <= GATE_RESET;
      stack_sel <= STACK_RESET;
      prio_lvl <= PRIO_RESET;
      rsvd <= RSVD_RESET;
      irq_take <= 1'h0;
      rdata <= '0;
      pstate <= ST_ON;
      power_off <= POWER_OFF_RESET;
    end else begin
      gate <= next_gate;
      stack_sel <= next_stack_sel;
      prio_lvl <= next_prio_lvl;
      rsvd <= next_rsvd;
      irq_take <= next_irq_take;
      rdata <= next_rdata;
      pstate <= next_pstate;
      power_off <= next_power_off;
    end
  end

  assign rdata_o = rdata;
  assign irq_take_o = irq_take;
  assign user_stack_sel_o = stack_sel;
  assign processor_priority_level_o = prio_lvl;
  assign power_off_o = power_off;

  sequence s_wake_seen;
    pstate == ST_OFF && power_off_wake_pin_i;
  endsequence

  a_take_needs_gate: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !gate && !irq_ack_i |=> !irq_take_o) else $error("request taken with gate closed");
  a_ack_clears_gate: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_ack_i |=> !gate) else $error("gate still open after acknowledge");
  a_stack_out: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(user_stack_sel_o) |-> $past(flag_wr) && $past(wdata_i[STACK_BIT]))
    else $error("user stack chosen without a write");
  a_trap_clears_stack: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (trap_i.valid && trap_i.number <= 6'h1F) || (irq_ack_i && irq_ack_hw_i)
    |=> !user_stack_sel_o) else $error("stack choice not cleared");
  a_high_trap_keeps: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    trap_i.valid && trap_i.number > 6'h1F && !irq_ack_i && !flag_wr
    |=> $stable(stack_sel)) else $error("high trap altered stack choice");
  a_level_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    flag_wr |=> prio_lvl == $past(wdata_i[14:12])) else $error("level not written");
  a_prio_compare: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_i.valid && irq_i.prio <= prio_lvl |=> !irq_take_o) else $error("low priority taken");
  a_take_both: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_i.valid && gate && irq_i.prio > prio_lvl && !irq_ack_i && pstate == ST_ON
    |=> irq_take_o) else $error("eligible request not taken");
  a_wake_exit: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_wake_seen |=> power_off_o ##1 !power_off_o) else $error("wake did not end power-off");

  sequence s_hw_ack;
    irq_ack_i && irq_ack_hw_i;
  endsequence

  sequence s_kernel_trap;
    trap_i.valid && trap_i.number <= TRAP_KERNEL_MAX;
  endsequence

  sequence s_flag_read;
    rd_i && addr_i == FLAG_OFFSET;
  endsequence

  sequence s_enter_off;
    pstate == ST_ON && power_off_req_i;
  endsequence

  // The reset check has no disable clause on purpose: it must hold while reset is low.
  a_reset_state: assert property (@(posedge mclk_i)
    !rst_b_i
    |-> !gate && !stack_sel && prio_lvl == PRIO_RESET && !irq_take_o && !power_off_o)
    else $error("state not cleared by reset");

  a_gate_write_open: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    flag_wr && wdata_i[GATE_BIT] && !irq_ack_i
    |=> gate)
    else $error("gate not opened by write");

  a_gate_write_shut: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    flag_wr && !wdata_i[GATE_BIT]
    |=> !gate)
    else $error("gate not closed by write");

  a_gate_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !flag_wr && !irq_ack_i
    |=> $stable(gate))
    else $error("gate changed without cause");

  // A write and an acknowledge in one cycle must still leave the handler masked.
  a_gate_ack_wins: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_ack_i && flag_wr
    |=> !gate)
    else $error("write beat acknowledge on gate");

  a_take_ack: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_ack_i
    |=> !irq_take_o)
    else $error("request taken in acknowledge cycle");

  a_hw_ack_stack: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_hw_ack
    |=> !stack_sel)
    else $error("hardware acknowledge kept user stack");

  a_kernel_trap_stack: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_kernel_trap
    |=> !stack_sel)
    else $error("kernel trap kept user stack");

  // Software acknowledges leave the stack choice alone; only kernel traps, hardware acknowledges and writes may move it.
  a_soft_ack_keeps: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_ack_i && !irq_ack_hw_i && !kernel_trap && !flag_wr
    |=> $stable(stack_sel))
    else $error("software acknowledge moved stack choice");

  a_read_stack: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_flag_read
    |=> rdata_o[STACK_BIT] == $past(stack_sel))
    else $error("stack choice read back wrong");

  a_read_gate: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_flag_read
    |=> rdata_o[GATE_BIT] == $past(gate))
    else $error("gate read back wrong");

  a_read_level: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_flag_read
    |=> rdata_o[PRIO_LSB +: PRIO_W] == $past(prio_lvl))
    else $error("level read back wrong");

  a_level_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !flag_wr
    |=> $stable(prio_lvl))
    else $error("level changed without write");

  a_rsvd_store: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    flag_wr
    |=> rsvd == $past(wdata_i[RSVD_BIT]))
    else $error("reserved bit not stored");

  a_take_level: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_take_o
    |-> $past(irq_i.prio) > $past(prio_lvl))
    else $error("request taken at or below level");

  a_take_gate_open: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    irq_take_o
    |-> $past(gate) && $past(irq_i.valid))
    else $error("request taken without open gate");

  a_take_no_valid: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !irq_i.valid
    |=> !irq_take_o)
    else $error("take raised with no request");

  // Requests are held off while powered down; the sequencer is not running then.
  a_take_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    pstate != ST_ON
    |=> !irq_take_o)
    else $error("request taken while powered off");

  a_off_enter: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_enter_off
    |=> power_off_o)
    else $error("power-off not entered");

  // A wake pin tied low must keep the block asleep for good.
  a_off_stays: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    pstate == ST_OFF && !power_off_wake_pin_i
    |=> pstate == ST_OFF)
    else $error("power-off left without wake");

  a_wake_one: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    pstate == ST_WAKE
    |=> pstate == ST_ON && !power_off_o)
    else $error("wake state lasted too long");
endmodule : cpu_interrupt_flag_control

//--- common/intflag_pkg.sv
// Package with constants and carrier types for the interrupt flag control block.
package intflag_pkg;
  localparam int PRIO_W = 3;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] FLAG_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h1;
  // Bit positions inside the flag word.
  localparam int GATE_BIT = 6;
  localparam int STACK_BIT = 7;
  localparam int PRIO_LSB = 12;
  localparam int RSVD_BIT = 15;
  localparam logic GATE_RESET = 1'h0;
  localparam logic STACK_RESET = 1'h0;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
  localparam logic RSVD_RESET = 1'h0;
  localparam logic POWER_OFF_RESET = 1'h0;
  localparam logic [5:0] TRAP_KERNEL_MAX = 6'h1F;

  typedef struct packed {
    logic valid;
    logic [PRIO_W-1:0] prio;
  } irq_req_t;

  typedef struct packed {
    logic valid;
    logic [5:0] number;
  } trap_req_t;

  typedef enum logic [1:0] {
    ST_ON = 2'h0,
    ST_OFF = 2'h1,
    ST_WAKE = 2'h3
  } power_state_t;
endpackage : intflag_pkg

//--- test/irq_sequencer_model.sv
// Behavioural sequencer that acknowledges requests the flag block accepts.
`timescale 1ns/1ps
module irq_sequencer_model (
  input wire logic mclk_i,
  input wire logic en_i,
  input wire logic hw_i,
  input wire logic irq_take_i,
  output logic irq_ack_o,
  output logic irq_ack_hw_o
);
  initial begin
    irq_ack_o = 1'h0;
    irq_ack_hw_o = 1'h0;
  end
  // One pulse per acceptance, because the take output still stands in the ack cycle.
  always @(posedge mclk_i) begin
    irq_ack_o <= en_i && irq_take_i && !irq_ack_o;
    irq_ack_hw_o <= hw_i;
  end
endmodule : irq_sequencer_model

//--- test/cpu_interrupt_flag_control_tb.sv
// Testbench for the interrupt flag control block.
`timescale 1ns/1ps
module cpu_interrupt_flag_control_tb;
  import intflag_pkg::*;
  logic mclk_i = 0, wr = 0, rd = 0, pwr = 0, wake = 0, ack_en = 0, hw = 1;
  logic rst_b_i;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, d;
  irq_req_t irq = '0;
  trap_req_t trap = '0;
  logic ack, ack_hw, take, user_stack_pointer, poff;
  logic [PRIO_W-1:0] lvl;
  int num_errors = 0, tests_run = 0;
  cpu_interrupt_flag_control cpu_interrupt_flag_control_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_i(irq),
    .irq_ack_i(ack), .irq_ack_hw_i(ack_hw), .trap_i(trap), .power_off_req_i(pwr),
    .power_off_wake_pin_i(wake), .irq_take_o(take), .user_stack_sel_o(user_stack_pointer),
    .processor_priority_level_o(lvl), .power_off_o(poff));
  irq_sequencer_model irq_sequencer_model_i (.mclk_i(mclk_i), .en_i(ack_en), .hw_i(hw),
    .irq_take_i(take), .irq_ack_o(ack), .irq_ack_hw_o(ack_hw));
  initial forever #20 mclk_i = ~mclk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge mclk_i) {addr, wdata, wr} <= {a, v, 1'h1};
    @(posedge mclk_i) wr <= 1'h0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge mclk_i) {addr, rd} <= {a, 1'h1};
    @(posedge mclk_i) rd <= 1'h0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic results;
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    rst_b_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'h1;
    tick(1);
    chk({take, user_stack_pointer, lvl, poff}, 16'h0);
    wr_reg(FLAG_OFFSET, 16'h70C0);
    chk({user_stack_pointer, lvl}, 16'hF);
    @(posedge mclk_i) irq <= '{1'h1, 3'h7};
    tick(2);
    chk(take, 16'h0);
    wr_reg(FLAG_OFFSET, 16'h30C0);
    @(posedge mclk_i) irq <= '{1'h1, 3'h3};
    tick(2);
    chk(take, 16'h0);
    @(posedge mclk_i) irq <= '{1'h1, 3'h4};
    tick(2);
    chk(take, 16'h1);
    @(posedge mclk_i) {ack_en, hw} <= 2'h2;
    tick(4);
    chk({take, user_stack_pointer}, 16'h1);
    wr_reg(FLAG_OFFSET, 16'h30C0);
    @(posedge mclk_i) hw <= 1'h1;
    tick(4);
    chk({take, user_stack_pointer}, 16'h0);
    rd_reg(FLAG_OFFSET);
    chk(d & 16'h70C0, 16'h3000);
    @(posedge mclk_i) {ack_en, irq} <= '0;
    wr_reg(FLAG_OFFSET, 16'h00C0);
    @(posedge mclk_i) trap <= '{1'h1, 6'h20};
    @(posedge mclk_i) trap <= '{1'h1, TRAP_KERNEL_MAX};
    #1 chk(user_stack_pointer, 16'h1);
    @(posedge mclk_i) trap <= '0;
    #1 chk(user_stack_pointer, 16'h0);
    @(posedge mclk_i) pwr <= 1'h1;
    @(posedge mclk_i) pwr <= 1'h0;
    rd_reg(STATUS_OFFSET);
    chk({poff, d[1:0]}, 16'h5);
    @(posedge mclk_i) wake <= 1'h1;
    @(posedge mclk_i) wake <= 1'h0;
    tick(2);
    chk(poff, 16'h0);
    rd_reg(4'hF);
    chk(d, 16'h0);
    wr_reg(FLAG_OFFSET, 16'h70C0);
    @(posedge mclk_i) rst_b_i <= 1'h0;
    tick(1);
    chk({user_stack_pointer, lvl}, 16'h0);
    results();
  end
  initial begin
    repeat (500) @(posedge mclk_i);
    num_errors++;
    results();
  end
endmodule : cpu_interrupt_flag_control_tb
